// *** hw/pdo_port_d.sv ***
// port d alternate override with an axi4-lite register slave
// Summary of operation
// - pin 7 drives timer2 compare a when enabled and direction is output
// - pin 6 drives timer2 compare b when enabled and direction is output
// - pin 6 input feeds timer1 capture without overriding the pin
// - pin 5 drives timer1 compare a when enabled and direction is output
// - pin 4 drives timer1 compare b when enabled and direction is output
// - serial1 transmitter forces pin 3 output with tx data, pull-up off
// - serial1 receiver forces pin 2 input and feeds the receiver
// - pin 2 pull-up still follows its data bit, gated by global pull-up off
// - serial0 transmitter forces pin 1 output with tx data, pull-up off
// - serial0 receiver forces pin 0 input and feeds that receiver
// - pin 0 pull-up still follows its data bit, gated by global pull-up off
// - pin 3 is external irq 1 input, input kept enabled while enabled
// - pin 2 is external irq 0 input, input kept enabled while enabled
// - each pin feeds pin-change source 24..31; mask and group enable force input enable on
// - pin 4 also serves as serial1 external clock input
`default_nettype none
module pdo_port_d
    import pdo_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // axi4-lite slave
    input wire logic [5:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [5:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // peripherals
    input wire pdo_periph_t periph,
    input wire logic sleepInputsOff,
    output pdo_sense_t sense,
    // pads
    input wire logic [7:0] padIn,
    output logic [7:0] padOut,
    output logic [7:0] padOe,
    output logic [7:0] padPullup,
    output logic [7:0] padInEn
);
    // ==========================================
    // override table per pin
    function automatic pdo_ovr_t pinOvr(input int i, input pdo_periph_t p,
                                        input logic [7:0] data, input logic global_pullup_off,
                                        input logic [7:0] mask, input logic grp);
        pdo_ovr_t o;
        o = '0;
        o.inenOvrEn = mask[i] & grp;
        o.inenOvrVal = 1'b1;
        unique case (i)
            PIN_T2A:
            begin
                o.outvalOvrEn = p.timer2CompareAOn;
                o.outvalOvrVal = p.timer2CompareAOut;
            end
            PIN_T2B:
            begin
                o.outvalOvrEn = p.timer2CompareBOn;
                o.outvalOvrVal = p.timer2CompareBOut;
            end
            PIN_T1A:
            begin
                o.outvalOvrEn = p.timer1CompareAOn;
                o.outvalOvrVal = p.timer1CompareAOut;
            end
            PIN_T1B:
            begin
                o.outvalOvrEn = p.timer1CompareBOn;
                o.outvalOvrVal = p.timer1CompareBOut;
            end
            PIN_TX1:
            begin
                o.pullupOvrEn = p.serial1TxOn;
                o.dirOvrEn = p.serial1TxOn;
                o.dirOvrVal = 1'b1;
                o.outvalOvrEn = p.serial1TxOn;
                o.outvalOvrVal = p.serial1TxLine;
                o.inenOvrEn = o.inenOvrEn | p.extIrq1On;
            end
            PIN_RX1:
            begin
                o.pullupOvrEn = p.serial1RxOn;
                o.pullupOvrVal = data[i] & ~global_pullup_off;
                o.dirOvrEn = p.serial1RxOn;
                o.inenOvrEn = o.inenOvrEn | p.extIrq0On;
            end
            PIN_TX0:
            begin
                o.pullupOvrEn = p.serial0TxOn;
                o.dirOvrEn = p.serial0TxOn;
                o.dirOvrVal = 1'b1;
                o.outvalOvrEn = p.serial0TxOn;
                o.outvalOvrVal = p.serial0TxLine;
            end
            default:
            begin
                o.pullupOvrEn = p.serial0RxOn;
                o.pullupOvrVal = data[i] & ~global_pullup_off;
                o.dirOvrEn = p.serial0RxOn;
            end
        endcase
        return o;
    endfunction

    // ==========================================
    // register file and bus state
    logic [7:0] dirReg, dirNext, dataReg, dataNext, maskReg, maskNext;
    logic [1:0] ctrlReg, ctrlNext;
    logic awHeldReg, awHeldNext, wHeldReg, wHeldNext;
    logic [5:0] awAddrReg, awAddrNext;
    logic [31:0] wDataReg, wDataNext;
    logic wLaneReg, wLaneNext;
    logic bvalidNext, rvalidNext, awreadyNext, wreadyNext, arreadyNext;
    logic [1:0] brespNext, rrespNext;
    logic [31:0] rdataNext;
    logic doWrite;

    always_comb
    begin
        dirNext = dirReg;
        dataNext = dataReg;
        maskNext = maskReg;
        ctrlNext = ctrlReg;
        awHeldNext = awHeldReg;
        wHeldNext = wHeldReg;
        awAddrNext = awAddrReg;
        wDataNext = wDataReg;
        wLaneNext = wLaneReg;
        bvalidNext = bvalid;
        brespNext = bresp;
        rvalidNext = rvalid;
        rrespNext = rresp;
        rdataNext = rdata;
        if (awvalid && awready)
        begin
            awHeldNext = 1'b1;
            awAddrNext = awaddr;
        end
        if (wvalid && wready)
        begin
            wHeldNext = 1'b1;
            wDataNext = wdata;
            wLaneNext = wstrb[0];
        end
        doWrite = awHeldReg && wHeldReg && !bvalid;
        if (doWrite)
        begin
            awHeldNext = 1'b0;
            wHeldNext = 1'b0;
            bvalidNext = 1'b1;
            brespNext = RESP_OKAY;
            unique case (awAddrReg)
                DIR_OFFSET: if (wLaneReg) dirNext = wDataReg[7:0];
                DATA_OFFSET: if (wLaneReg) dataNext = wDataReg[7:0];
                CTRL_OFFSET: if (wLaneReg) ctrlNext = wDataReg[1:0];
                MASK_OFFSET: if (wLaneReg) maskNext = wDataReg[7:0];
                PINS_OFFSET, STATE_OFFSET: brespNext = RESP_OKAY;
                default: brespNext = RESP_SLVERR;
            endcase
        end
        else if (bvalid && bready)
        begin
            bvalidNext = 1'b0;
        end
        if (arvalid && arready)
        begin
            rvalidNext = 1'b1;
            rrespNext = RESP_OKAY;
            rdataNext = '0;
            unique case (araddr)
                DIR_OFFSET: rdataNext[7:0] = dirReg;
                DATA_OFFSET: rdataNext[7:0] = dataReg;
                CTRL_OFFSET: rdataNext[1:0] = ctrlReg;
                MASK_OFFSET: rdataNext[7:0] = maskReg;
                PINS_OFFSET: rdataNext[7:0] = padIn;
                STATE_OFFSET: rdataNext[7:0] = padOe;
                default: rrespNext = RESP_SLVERR;
            endcase
        end
        else if (rvalid && rready)
        begin
            rvalidNext = 1'b0;
        end
        awreadyNext = !awHeldNext && !bvalidNext;
        wreadyNext = !wHeldNext && !bvalidNext;
        arreadyNext = !rvalidNext;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            dirReg <= DIR_RESET;
            dataReg <= DATA_RESET;
            maskReg <= MASK_RESET;
            ctrlReg <= CTRL_RESET;
            awHeldReg <= 1'b0;
            wHeldReg <= 1'b0;
            awAddrReg <= '0;
            wDataReg <= '0;
            wLaneReg <= 1'b0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            rvalid <= 1'b0;
            rresp <= RESP_OKAY;
            rdata <= '0;
            awready <= 1'b0;
            wready <= 1'b0;
            arready <= 1'b0;
        end
        else
        begin
            dirReg <= dirNext;
            dataReg <= dataNext;
            maskReg <= maskNext;
            ctrlReg <= ctrlNext;
            awHeldReg <= awHeldNext;
            wHeldReg <= wHeldNext;
            awAddrReg <= awAddrNext;
            wDataReg <= wDataNext;
            wLaneReg <= wLaneNext;
            bvalid <= bvalidNext;
            bresp <= brespNext;
            rvalid <= rvalidNext;
            rresp <= rrespNext;
            rdata <= rdataNext;
            awready <= awreadyNext;
            wready <= wreadyNext;
            arready <= arreadyNext;
        end
    end

    // ==========================================
    // pin muxing
    logic [7:0] outNext, oeNext, puNext, ieNext;
    logic [7:0] diNow;
    pdo_sense_t senseNext;

    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            pdo_ovr_t o;
            o = pinOvr(i, periph, dataReg, ctrlReg[CTRL_PULLUP_OFF_BIT], maskReg,
                       ctrlReg[CTRL_GROUP_ON_BIT]);
            oeNext[i] = o.dirOvrEn ? o.dirOvrVal : dirReg[i];
            outNext[i] = o.outvalOvrEn ? o.outvalOvrVal : dataReg[i];
            puNext[i] = o.pullupOvrEn ? o.pullupOvrVal
                      : (~oeNext[i] & dataReg[i] & ~ctrlReg[CTRL_PULLUP_OFF_BIT]);
            ieNext[i] = o.inenOvrEn ? o.inenOvrVal : ~sleepInputsOff;
            diNow[i] = padIn[i] & ieNext[i];
        end
        senseNext.timer1CaptureIn = diNow[PIN_T2B];
        senseNext.serial0RxLine = diNow[PIN_RX0];
        senseNext.serial1RxLine = diNow[PIN_RX1];
        senseNext.serial1ExtClock = diNow[PIN_T1B];
        senseNext.extIrq0In = diNow[PIN_RX1];
        senseNext.extIrq1In = diNow[PIN_TX1];
        senseNext.pinchangeSrc = diNow;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            padOut <= '0;
            padOe <= '0;
            padPullup <= '0;
            padInEn <= '0;
            sense <= '0;
        end
        else
        begin
            padOut <= outNext;
            padOe <= oeNext;
            padPullup <= puNext;
            padInEn <= ieNext;
            sense <= senseNext;
        end
    end

    // ==========================================
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    a_t2a_drive: assert property (rst_b && periph.timer2CompareAOn && dirReg[7]
        |=> padOe[7] && padOut[7] == $past(periph.timer2CompareAOut)) else $error("t2a");
    a_t2b_drive: assert property (rst_b && periph.timer2CompareBOn && dirReg[6]
        |=> padOut[6] == $past(periph.timer2CompareBOut)) else $error("t2b");
    a_capture_path: assert property (rst_b && ieNext[6]
        |=> sense.timer1CaptureIn == $past(padIn[6])) else $error("capture");
    a_t1_drive: assert property (rst_b && periph.timer1CompareAOn && periph.timer1CompareBOn
        |=> padOut[5:4] == {$past(periph.timer1CompareAOut), $past(periph.timer1CompareBOut)})
        else $error("t1 compare");
    a_tx1_force: assert property (rst_b && periph.serial1TxOn
        |=> padOe[3] && !padPullup[3] && padOut[3] == $past(periph.serial1TxLine))
        else $error("tx1");
    a_rx1_pullup: assert property (rst_b && periph.serial1RxOn
        |=> !padOe[2] && padPullup[2] == ($past(dataReg[2]) && !$past(ctrlReg[0])))
        else $error("rx1");
    a_tx0_force: assert property (rst_b && periph.serial0TxOn
        |=> padOe[1] && !padPullup[1] && padOut[1] == $past(periph.serial0TxLine))
        else $error("tx0");
    a_rx0_pullup: assert property (rst_b && periph.serial0RxOn
        |=> !padOe[0] && padPullup[0] == ($past(dataReg[0]) && !$past(ctrlReg[0])))
        else $error("rx0");
    a_irq_inen: assert property (rst_b && periph.extIrq0On && periph.extIrq1On
        |=> padInEn[3:2] == 2'h3) else $error("irq input enable");
    a_pc_inen: assert property (rst_b && ctrlReg[1] && maskReg == 8'hff
        |=> padInEn == 8'hff) else $error("pin change input enable");
    a_plain_dir: assert property (rst_b && periph == '0
        |=> padOe == $past(dirReg) && padOut == $past(dataReg)) else $error("plain port");
    a_bus_resp: assert property (awHeldReg && wHeldReg && !bvalid
        |=> bvalid) else $error("write response");

    c_tx1: cover property (periph.serial1TxOn ##1 padOe[3]);
    c_pwm: cover property (periph.timer2CompareAOn && dirReg[7] ##1 padOut[7]);
    c_write: cover property (bvalid && bready);
    c_read: cover property (rvalid && rready);
endmodule // pdo_port_d
`default_nettype wire

// *** hw/pdo_pkg.sv ***
// package for the port d alternate override block
`default_nettype none
package pdo_pkg;
    // ==========================================
    // register map (byte addresses)
    localparam logic [5:0] DIR_OFFSET = 6'h00;
    localparam logic [5:0] DATA_OFFSET = 6'h04;
    localparam logic [5:0] CTRL_OFFSET = 6'h08;
    localparam logic [5:0] MASK_OFFSET = 6'h0c;
    localparam logic [5:0] PINS_OFFSET = 6'h10;
    localparam logic [5:0] STATE_OFFSET = 6'h14;
    // ==========================================
    // fields and reset values
    localparam int CTRL_PULLUP_OFF_BIT = 0;
    localparam int CTRL_GROUP_ON_BIT = 1;
    localparam logic [7:0] DIR_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ==========================================
    // pin numbers of the alternate functions
    localparam int PIN_RX0 = 0;
    localparam int PIN_TX0 = 1;
    localparam int PIN_RX1 = 2;
    localparam int PIN_TX1 = 3;
    localparam int PIN_T1B = 4;
    localparam int PIN_T1A = 5;
    localparam int PIN_T2B = 6;
    localparam int PIN_T2A = 7;
    // ==========================================
    // carriers
    typedef struct packed {
        logic timer2CompareAOn;
        logic timer2CompareAOut;
        logic timer2CompareBOn;
        logic timer2CompareBOut;
        logic timer1CompareAOn;
        logic timer1CompareAOut;
        logic timer1CompareBOn;
        logic timer1CompareBOut;
        logic serial1TxOn;
        logic serial1TxLine;
        logic serial1RxOn;
        logic serial0TxOn;
        logic serial0TxLine;
        logic serial0RxOn;
        logic extIrq0On;
        logic extIrq1On;
    } pdo_periph_t;
    typedef struct packed {
        logic timer1CaptureIn;
        logic serial0RxLine;
        logic serial1RxLine;
        logic serial1ExtClock;
        logic extIrq0In;
        logic extIrq1In;
        logic [7:0] pinchangeSrc;
    } pdo_sense_t;
    typedef struct packed {
        logic pullupOvrEn;
        logic pullupOvrVal;
        logic dirOvrEn;
        logic dirOvrVal;
        logic outvalOvrEn;
        logic outvalOvrVal;
        logic inenOvrEn;
        logic inenOvrVal;
    } pdo_ovr_t;
endpackage
`default_nettype wire

// *** sim/pdo_periph_model.sv ***
// peripheral side model: override enables and timer/serial waveforms
`default_nettype none
module pdo_periph_model
    import pdo_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // commands from the bench
    input wire pdo_periph_t cmd,
    input wire logic toggle,
    // towards the port
    output pdo_periph_t periph
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================
    // enables follow cmd, output lines flip every cycle when toggling
    pdo_periph_t perNext;
    always_comb
    begin
        perNext = cmd;
        if (toggle)
        begin
            perNext.timer2CompareAOut = ~periph.timer2CompareAOut;
            perNext.timer2CompareBOut = ~periph.timer2CompareBOut;
            perNext.timer1CompareAOut = ~periph.timer1CompareAOut;
            perNext.timer1CompareBOut = ~periph.timer1CompareBOut;
            perNext.serial1TxLine = ~periph.serial1TxLine;
            perNext.serial0TxLine = ~periph.serial0TxLine;
        end
    end
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
            periph <= '0;
        else
            periph <= perNext;
    end
endmodule // pdo_periph_model
`default_nettype wire

// *** sim/tb_port_d_alternate_override.sv ***
// self-checking bench for the port d override block
`default_nettype none
`define CHK(nm, e, g) begin samplesChecked++; if ((g) !== (e)) begin failures++; \
    $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb_port_d_alternate_override
    import pdo_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk, rst_b, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, toggle, sleepInputsOff, slS;
    logic [5:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, ctlR;
    logic [7:0] padIn, padS, padOut, padOe, padPullup, padInEn, dirR, datR, mskR;
    pdo_periph_t cmd, periph, perS;
    pdo_sense_t sense;
    int failures, samplesChecked;
    // ==========================================
    // clock, partner and design
    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    always @(posedge mclk)
    begin
        perS = periph;
        padS = padIn;
        slS = sleepInputsOff;
    end
    pdo_periph_model i_peri (.mclk(mclk), .rst_b(rst_b), .cmd(cmd), .toggle(toggle),
        .periph(periph));
    pdo_port_d i_dut (.mclk(mclk), .rst_b(rst_b), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .periph(periph),
        .sleepInputsOff(sleepInputsOff), .sense(sense), .padIn(padIn), .padOut(padOut),
        .padOe(padOe), .padPullup(padPullup), .padInEn(padInEn));
    // ==========================================
    // closing and bus tasks
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samplesChecked, failures);
        if (failures == 0 && samplesChecked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic tmo(input int n);
        if (n >= 40)
        begin
            failures++;
            $display("MISMATCH handshake exp answer got none");
            print_verdict();
        end
    endtask
    task automatic axiWr(input logic [5:0] a, input logic [7:0] d, input logic [1:0] r,
        input logic s = 1'b1);
        logic aw, w;
        int n;
        aw = 1'b1;
        w = 1'b1;
        n = 0;
        @(posedge mclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        wstrb <= {3'h7, s};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (n < 40)
        begin
            @(posedge mclk);
            n++;
            if (!aw && !w && bvalid)
                break;
            if (awready)
                aw = 1'b0;
            if (wready)
                w = 1'b0;
            awvalid <= aw;
            wvalid <= w;
        end
        tmo(n);
        bready <= 1'b0;
        `CHK("bresp", r, bresp)
        if (s && r === RESP_OKAY && a == DIR_OFFSET) dirR = d;
        if (s && r === RESP_OKAY && a == DATA_OFFSET) datR = d;
        if (s && r === RESP_OKAY && a == CTRL_OFFSET) ctlR = d[1:0];
        if (s && r === RESP_OKAY && a == MASK_OFFSET) mskR = d;
    endtask
    task automatic axiRd(input logic [5:0] a, input logic [31:0] e, input logic [1:0] r);
        int n;
        n = 0;
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (n < 40)
        begin
            @(posedge mclk);
            n++;
            if (rvalid)
                break;
            if (arready)
                arvalid <= 1'b0;
        end
        tmo(n);
        rready <= 1'b0;
        `CHK("rresp", r, rresp)
        if (r === RESP_OKAY) `CHK("rdata", e, rdata)
    endtask
    // ==========================================
    // pin stimulus and expected pad state
    task automatic setIn(input logic [15:0] c, input logic tg, input logic sl,
        input logic [7:0] pi);
        @(posedge mclk);
        cmd <= c;
        toggle <= tg;
        sleepInputsOff <= sl;
        padIn <= pi;
    endtask
    task automatic expPads(output logic [7:0] oe, out, pu, ie);
        pdo_periph_t p;
        logic global_pullup_off;
        p = perS;
        global_pullup_off = ctlR[CTRL_PULLUP_OFF_BIT];
        oe = dirR;
        out = datR;
        pu = ~dirR & datR & {8{~global_pullup_off}};
        ie = {8{~slS}} | (mskR & {8{ctlR[CTRL_GROUP_ON_BIT]}});
        if (p.timer2CompareAOn) out[7] = p.timer2CompareAOut;
        if (p.timer2CompareBOn) out[6] = p.timer2CompareBOut;
        if (p.timer1CompareAOn) out[5] = p.timer1CompareAOut;
        if (p.timer1CompareBOn) out[4] = p.timer1CompareBOut;
        if (p.serial1TxOn) {oe[3], out[3], pu[3]} = {1'b1, p.serial1TxLine, 1'b0};
        if (p.serial0TxOn) {oe[1], out[1], pu[1]} = {1'b1, p.serial0TxLine, 1'b0};
        if (p.serial1RxOn) {oe[2], pu[2]} = {1'b0, datR[2] & ~global_pullup_off};
        if (p.serial0RxOn) {oe[0], pu[0]} = {1'b0, datR[0] & ~global_pullup_off};
        ie[2] = ie[2] | p.extIrq0On;
        ie[3] = ie[3] | p.extIrq1On;
    endtask
    task automatic chk(input int n);
        logic [7:0] oe, out, pu, ie;
        pdo_sense_t es;
        repeat (2) @(posedge mclk);
        repeat (n)
        begin
            @(negedge mclk);
            expPads(oe, out, pu, ie);
            es = {padS[6] & ie[6], padS[0] & ie[0], padS[2] & ie[2], padS[4] & ie[4],
                padS[2] & ie[2], padS[3] & ie[3], padS & ie};
            `CHK("padOe", oe, padOe)
            `CHK("padOut", out & oe, padOut & padOe)
            `CHK("padPullup", pu, padPullup)
            `CHK("padInEn", ie, padInEn)
            `CHK("sense", es, sense)
        end
    endtask
    // ==========================================
    // main sequence
    initial
    begin
        {rst_b, awvalid, wvalid, bready, arvalid, rready, toggle, sleepInputsOff} = '0;
        {awaddr, araddr, wdata, wstrb, padIn, cmd} = '0;
        {dirR, datR, mskR, ctlR, failures, samplesChecked} = '0;
        repeat (4) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (2) @(posedge mclk);
        for (int i = 0; i < 4; i++) axiRd(6'(i * 4), 32'h0, RESP_OKAY);
        axiRd(6'h18, 32'h0, RESP_SLVERR);
        axiWr(6'h18, 8'hff, RESP_SLVERR);
        $display("test reset done");
        axiWr(DIR_OFFSET, 8'h0f, RESP_OKAY);
        axiWr(DATA_OFFSET, 8'h5a, RESP_OKAY);
        setIn(16'h0000, 1'b0, 1'b0, 8'ha5);
        chk(3);
        axiRd(STATE_OFFSET, 32'h0f, RESP_OKAY);
        axiWr(PINS_OFFSET, 8'h00, RESP_OKAY);
        axiRd(PINS_OFFSET, 32'ha5, RESP_OKAY);
        axiWr(DIR_OFFSET, 8'hff, RESP_OKAY, 1'b0);
        axiRd(DIR_OFFSET, 32'h0f, RESP_OKAY);
        $display("test default done");
        axiWr(DIR_OFFSET, 8'hf0, RESP_OKAY);
        setIn(16'haa00, 1'b1, 1'b0, 8'h5a);
        chk(4);
        axiWr(DIR_OFFSET, 8'h50, RESP_OKAY);
        chk(3);
        $display("test compare done");
        axiWr(DIR_OFFSET, 8'h05, RESP_OKAY);
        axiWr(DATA_OFFSET, 8'h0f, RESP_OKAY);
        setIn(16'h00b4, 1'b1, 1'b0, 8'h3c);
        chk(4);
        axiWr(CTRL_OFFSET, 8'h01, RESP_OKAY);
        chk(2);
        $display("test serial done");
        axiWr(CTRL_OFFSET, 8'h02, RESP_OKAY);
        axiWr(MASK_OFFSET, 8'h81, RESP_OKAY);
        setIn(16'h0002, 1'b0, 1'b1, 8'hff);
        chk(2);
        setIn(16'h0003, 1'b0, 1'b1, 8'hd5);
        chk(2);
        axiWr(MASK_OFFSET, 8'hff, RESP_OKAY);
        chk(2);
        axiWr(CTRL_OFFSET, 8'h00, RESP_OKAY);
        chk(2);
        $display("test inputs done");
        print_verdict();
    end
endmodule // tb_port_d_alternate_override
`default_nettype wire
